// *** design/sto_seq_map.svh ***
`ifndef STO_SEQ_MAP_SVH
`define STO_SEQ_MAP_SVH
// register offsets (byte addresses)
`define STO_REG_CTRL     8'h00
`define STO_REG_STATUS   8'h04
`define STO_REG_IRQ_STAT 8'h08
`define STO_REG_IRQ_MASK 8'h0C
`define STO_REG_LIMIT    8'h10
`define STO_REG_PERIOD   8'h14
`define STO_REG_FAULT    8'h18
// ctrl fields
`define STO_CTRL_EN_BIT    0
`define STO_CTRL_FCLR_BIT  1
// status fields
`define STO_ST_ACTIVE_BIT  0
`define STO_ST_INHIB_BIT   1
`define STO_ST_READY_BIT   2
`define STO_ST_RUN_BIT     3
`define STO_ST_FAULT_BIT   4
`define STO_ST_SAFEOK_BIT  5
// interrupt event bits
`define STO_EV_SELECT   0
`define STO_EV_DESELECT 1
`define STO_EV_FAULT    2
`define STO_EV_WIDTH    3
// reset values
`define STO_LIMIT_RST  16'h7FFF
`define STO_PERIOD_RST 16'h0028
// fault codes
`define STO_FLT_MISMATCH 2'h1
`define STO_FLT_LIMIT    2'h2
`endif

// *** design/sto_seq_pkg.sv ***
package sto_seq_pkg;
  typedef enum logic [2:0] {
    STO_RUN_OFF   = 3'b000,
    STO_RUNNING   = 3'b001,
    STO_CUTOFF    = 3'b010,
    STO_INHIBITED = 3'b011,
    STO_READY     = 3'b100,
    STO_STOPPING  = 3'b101
  } sto_state_e;
endpackage

// *** design/sto_sync.sv ***
`timescale 1ns/1ps
module sto_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] meta_q;

  initial begin
    if (WIDTH < 1) $error("sto_sync: WIDTH must be at least 1");
  end

  // first stage read only by the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q  <= '0;
      syncOut <= '0;
    end else begin
      meta_q  <= asyncIn;
      syncOut <= meta_q;
    end
  end
endmodule

// *** design/sto_seq.sv ***
// Functional notes
// - cutoff selection acts only when enabled in function selection; else ignored.
// - on selection, raise cutoff-active status readable by the controller.
// - on selection, drop the power stage enable while selection persists.
// - on selection, enter switch-on inhibit; no auto restart despite run command.
// - detect deselection, leave cutoff, keep inhibit until run command re-armed.
// - run command falling 1 to 0 after deselection clears inhibit; ready.
// - run command rising 0 to 1 when ready re-enables power stage.
// - periodically cross-compare redundant channels and check limit value.
// - detected fault raises safety fault message, then a stop reaction.
// - no safety settings in loaded configuration means functions come up disabled.
`timescale 1ns/1ps
`include "sto_seq_map.svh"
module sto_seq
  import sto_seq_pkg::*;
#(
  parameter int CHAN_W = 16,
  parameter int ADDR_W = 8
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              cutoffSelect,
  input  wire logic              runCommand,
  input  wire logic              cfgLoaded,
  input  wire logic              cfgHasSafety,
  input  wire logic [CHAN_W-1:0] chanA,
  input  wire logic [CHAN_W-1:0] chanB,
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [31:0]       regWdata,
  input  wire logic              regWrite,
  input  wire logic              regRead,
  output logic      [31:0]       regRdata,
  output logic                   powerEnable,
  output logic                   cutoffActive,
  output logic                   switchOnInhibit,
  output logic                   safetyFault,
  output logic                   stopRequest,
  output logic                   irq
);
  initial begin
    if (CHAN_W < 1 || CHAN_W > 16) $error("sto_seq: CHAN_W must be 1..16");
    if (ADDR_W < 5) $error("sto_seq: ADDR_W must be at least 5");
  end

  // synchronised inputs
  logic [1:0] syncIn;
  logic       selSync;
  logic       runSync;
  logic       selPrev_q;
  logic       runPrev_q;

  sto_sync #(
    .WIDTH (2)
  ) u_sync (
    .clk     (clk),
    .rst_n   (rst_n),
    .asyncIn ({cutoffSelect, runCommand}),
    .syncOut (syncIn)
  );

  assign selSync = syncIn[1];
  assign runSync = syncIn[0];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      selPrev_q <= 1'b0;
      runPrev_q <= 1'b0;
    end else begin
      selPrev_q <= selSync;
      runPrev_q <= runSync;
    end
  end

  wire runFall = runPrev_q & ~runSync;
  wire runRise = ~runPrev_q & runSync;

  // configuration: safety settings latched when the configuration is loaded
  logic safeCfgOk_q;
  logic enable_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      safeCfgOk_q <= 1'b0;
    end else if (cfgLoaded) begin
      safeCfgOk_q <= cfgHasSafety;
    end
  end

  // register decode
  wire wrCtrl  = regWrite && (regAddr == ADDR_W'(`STO_REG_CTRL));
  wire wrIStat = regWrite && (regAddr == ADDR_W'(`STO_REG_IRQ_STAT));
  wire wrIMask = regWrite && (regAddr == ADDR_W'(`STO_REG_IRQ_MASK));
  wire wrLimit = regWrite && (regAddr == ADDR_W'(`STO_REG_LIMIT));
  wire wrPer   = regWrite && (regAddr == ADDR_W'(`STO_REG_PERIOD));
  wire faultClr = wrCtrl && regWdata[`STO_CTRL_FCLR_BIT];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      enable_q <= 1'b0;
    end else if (wrCtrl) begin
      enable_q <= regWdata[`STO_CTRL_EN_BIT];
    end
  end

  // without loaded safety settings the function stays off regardless of software
  wire cutoffEn = enable_q & safeCfgOk_q;
  wire selEff   = selSync & cutoffEn;
  wire selRise  = selEff & ~(selPrev_q & cutoffEn);

  // cross-comparison of monitoring channels
  logic [15:0]       limit_q;
  logic [15:0]       period_q;
  logic [15:0]       tick_q;
  logic [CHAN_W-1:0] cmpA_q;
  logic [CHAN_W-1:0] cmpB_q;
  logic [1:0]        faultCode_q;
  logic              fault_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      limit_q  <= `STO_LIMIT_RST;
      period_q <= `STO_PERIOD_RST;
    end else begin
      if (wrLimit) limit_q <= regWdata[15:0];
      if (wrPer) period_q <= regWdata[15:0];
    end
  end

  wire tickDone = (tick_q == 16'h0000);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_q <= `STO_PERIOD_RST;
      cmpA_q <= '0;
      cmpB_q <= '0;
    end else if (tickDone) begin
      tick_q <= period_q;
      cmpA_q <= chanA;
      cmpB_q <= chanB;
    end else begin
      tick_q <= tick_q - 16'h0001;
    end
  end

  // compare one cycle after sampling so both channels are taken in the same edge
  logic cmpPend_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) cmpPend_q <= 1'b0;
    else cmpPend_q <= tickDone;
  end

  wire mismatch  = cmpPend_q && (cmpA_q != cmpB_q);
  wire overLimit = cmpPend_q && (16'(cmpA_q) > limit_q);
  wire faultDet  = cutoffEn && (mismatch || overLimit);
  wire [1:0] faultCodeD = mismatch ? `STO_FLT_MISMATCH : `STO_FLT_LIMIT;

  // fault stays until software clears it; a new detection wins over the clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_q     <= 1'b0;
      faultCode_q <= 2'h0;
    end else if (faultDet) begin
      fault_q     <= 1'b1;
      faultCode_q <= faultCodeD;
    end else if (faultClr) begin
      fault_q     <= 1'b0;
      faultCode_q <= 2'h0;
    end
  end

  // sequencer
  sto_state_e state_q;
  sto_state_e state_d;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      STO_RUN_OFF: begin
        if (selEff) state_d = STO_CUTOFF;
        else if (fault_q) state_d = STO_STOPPING;
        else if (runRise) state_d = STO_RUNNING;
      end
      STO_RUNNING: begin
        if (selEff) state_d = STO_CUTOFF;
        else if (fault_q) state_d = STO_STOPPING;
        else if (runFall) state_d = STO_RUN_OFF;
      end
      STO_CUTOFF: begin
        if (!selEff) state_d = STO_INHIBITED;
      end
      STO_INHIBITED: begin
        if (selEff) state_d = STO_CUTOFF;
        else if (runFall || !runSync) state_d = STO_READY;
      end
      STO_READY: begin
        if (selEff) state_d = STO_CUTOFF;
        else if (fault_q) state_d = STO_STOPPING;
        else if (runRise) state_d = STO_RUNNING;
      end
      STO_STOPPING: begin
        if (selEff) state_d = STO_CUTOFF;
        else if (!fault_q && !runSync) state_d = STO_RUN_OFF;
      end
      default: state_d = STO_CUTOFF;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) state_q <= STO_RUN_OFF;
    else state_q <= state_d;
  end

  // outputs from flops, computed from the next state except safetyFault, which is taken from fault_q
  wire cutoffD  = (state_d == STO_CUTOFF);
  wire inhibitD = (state_d == STO_CUTOFF) || (state_d == STO_INHIBITED);
  wire powerD   = (state_d == STO_RUNNING) && !selEff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      powerEnable     <= 1'b0;
      cutoffActive    <= 1'b0;
      switchOnInhibit <= 1'b0;
      safetyFault     <= 1'b0;
      stopRequest     <= 1'b0;
    end else begin
      powerEnable     <= powerD;
      cutoffActive    <= cutoffD;
      switchOnInhibit <= inhibitD;
      safetyFault     <= fault_q;
      stopRequest     <= (state_d == STO_STOPPING);
    end
  end

  // interrupts: sticky status, write one to clear, set wins
  logic [`STO_EV_WIDTH-1:0] irqStat_q;
  logic [`STO_EV_WIDTH-1:0] irqMask_q;
  logic [`STO_EV_WIDTH-1:0] evSet;
  logic [`STO_EV_WIDTH-1:0] evClr;

  assign evSet[`STO_EV_SELECT]   = selRise;
  assign evSet[`STO_EV_DESELECT] = (state_q == STO_CUTOFF) && (state_d == STO_INHIBITED);
  assign evSet[`STO_EV_FAULT]    = faultDet & ~fault_q;
  assign evClr = wrIStat ? regWdata[`STO_EV_WIDTH-1:0] : '0;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irqStat_q <= '0;
      irqMask_q <= '0;
      irq       <= 1'b0;
    end else begin
      irqStat_q <= (irqStat_q & ~evClr) | evSet;
      if (wrIMask) irqMask_q <= regWdata[`STO_EV_WIDTH-1:0];
      irq <= |(((irqStat_q & ~evClr) | evSet) & (wrIMask ? regWdata[`STO_EV_WIDTH-1:0] : irqMask_q));
    end
  end

  // read path
  logic [31:0] statusWord;
  always_comb begin
    statusWord = 32'h0000_0000;
    statusWord[`STO_ST_ACTIVE_BIT] = cutoffActive;
    statusWord[`STO_ST_INHIB_BIT]  = switchOnInhibit;
    statusWord[`STO_ST_READY_BIT]  = (state_q == STO_READY);
    statusWord[`STO_ST_RUN_BIT]    = powerEnable;
    statusWord[`STO_ST_FAULT_BIT]  = fault_q;
    statusWord[`STO_ST_SAFEOK_BIT] = safeCfgOk_q;
  end

  logic [31:0] rdMux;
  always_comb begin
    rdMux = 32'h0000_0000;
    unique case (regAddr)
      ADDR_W'(`STO_REG_CTRL):     rdMux = {31'h0, enable_q};
      ADDR_W'(`STO_REG_STATUS):   rdMux = statusWord;
      ADDR_W'(`STO_REG_IRQ_STAT): rdMux = {29'h0, irqStat_q};
      ADDR_W'(`STO_REG_IRQ_MASK): rdMux = {29'h0, irqMask_q};
      ADDR_W'(`STO_REG_LIMIT):    rdMux = {16'h0, limit_q};
      ADDR_W'(`STO_REG_PERIOD):   rdMux = {16'h0, period_q};
      ADDR_W'(`STO_REG_FAULT):    rdMux = {30'h0, faultCode_q};
      default:                    rdMux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) regRdata <= 32'h0000_0000;
    else if (regRead) regRdata <= rdMux;
    else regRdata <= 32'h0000_0000;
  end
endmodule

// *** sim/sto_seq_monitor.sv ***
`timescale 1ns/1ps
module sto_seq_monitor (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        cutoffSelect,
  input wire logic        runCommand,
  input wire logic        regRead,
  input wire logic [31:0] regRdata,
  input wire logic        powerEnable,
  input wire logic        cutoffActive,
  input wire logic        switchOnInhibit,
  input wire logic        safetyFault,
  input wire logic        stopRequest,
  input wire logic        irq
);
  default clocking mc @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_cut_no_power: assert property (cutoffActive |-> !powerEnable)
    else $error("power enabled during cutoff");
  a_cut_inhibits: assert property (cutoffActive |-> switchOnInhibit)
    else $error("no inhibit during cutoff");
  a_select_cause: assert property ($rose(cutoffActive) |-> $past(cutoffSelect, 3))
    else $error("cutoff without selection");
  a_fault_stops: assert property ($rose(safetyFault) |-> ##[0:2] stopRequest)
    else $error("fault without stop");
  a_stop_no_power: assert property (stopRequest |-> !powerEnable)
    else $error("power during stop");
  a_restart_run: assert property ($rose(powerEnable) |-> $past(runCommand, 3))
    else $error("power without run command");
  a_no_auto_start: assert property ($rose(powerEnable) |-> !$past(switchOnInhibit))
    else $error("restart while inhibited");
  a_read_idle: assert property (!$past(regRead) |-> regRdata == 32'h0)
    else $error("read data outside read slot");
  c_cutoff: cover property ($rose(cutoffActive));
  c_fault: cover property ($rose(safetyFault));
  c_irq: cover property ($rose(irq));
endmodule
bind sto_seq sto_seq_monitor uMon (.clk(clk), .rst_n(rst_n), .cutoffSelect(cutoffSelect),
  .runCommand(runCommand), .regRead(regRead), .regRdata(regRdata), .powerEnable(powerEnable),
  .cutoffActive(cutoffActive), .switchOnInhibit(switchOnInhibit), .safetyFault(safetyFault),
  .stopRequest(stopRequest), .irq(irq));

// *** sim/sto_seq_ctrl_model.sv ***
`timescale 1ns/1ps
module sto_seq_ctrl_model (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic selReq,
  input  wire logic runReq,
  output logic      cutoffSelect,
  output logic      runCommand
);
  // outputs change only after an edge, like a real controller's output stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cutoffSelect <= 1'b0;
      runCommand   <= 1'b0;
    end else begin
      cutoffSelect <= selReq;
      runCommand   <= runReq;
    end
  end
endmodule

// *** sim/sto_seq_tb_top.sv ***
`timescale 1ns/1ps
`include "sto_seq_map.svh"
`define CHK(a, e) begin numChecks++; if ((a) !== (e)) begin numErrors++; \
  $display("Error %0t: got %h want %h", $time, a, e); end end
module safe_torque_off_sequencer_tb_top;
  logic clk = 0, rst_n = 0, selReq = 0, runReq = 0, cfgLoaded = 0, cfgHasSafety = 0;
  logic regWrite = 0, regRead = 0, cutoffSelect, runCommand;
  logic [15:0] chanA = 16'h0010, chanB = 16'h0010;
  logic [7:0]  regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0, regRdata;
  logic powerEnable, cutoffActive, switchOnInhibit, safetyFault, stopRequest, irq;
  int numErrors = 0, numChecks = 0;
  logic [7:0]  rowAddr [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C};
  // status shows the latched safe configuration taken in at boot
  logic [31:0] rowVal  [8] = '{32'h0, 32'h20, 32'h0, 32'h0, 32'h7FFF, 32'h28, 32'h0, 32'h0};
  always #12.5 clk = ~clk;
  sto_seq_ctrl_model uCtrl (.clk(clk), .rst_n(rst_n), .selReq(selReq), .runReq(runReq),
    .cutoffSelect(cutoffSelect), .runCommand(runCommand));
  sto_seq DUT (.clk(clk), .rst_n(rst_n), .cutoffSelect(cutoffSelect), .runCommand(runCommand),
    .cfgLoaded(cfgLoaded), .cfgHasSafety(cfgHasSafety), .chanA(chanA), .chanB(chanB),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .powerEnable(powerEnable), .cutoffActive(cutoffActive),
    .switchOnInhibit(switchOnInhibit), .safetyFault(safetyFault), .stopRequest(stopRequest), .irq(irq));
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regWrite <= 1'b1; regAddr <= a; regWdata <= d;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    regRead <= 1'b1; regAddr <= a;
    @(posedge clk);
    regRead <= 1'b0;
    @(negedge clk);
    `CHK(regRdata, e)
  endtask
  // two sync flops plus model and output flop, with margin
  task automatic settle();
    repeat (6) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic boot(input logic safe);
    rst_n = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1; cfgLoaded <= 1'b1; cfgHasSafety <= safe;
    @(posedge clk);
    cfgLoaded <= 1'b0;
  endtask
  task automatic testDone();
    $display("checks %0d errors %0d", numChecks, numErrors);
    if (numErrors == 0 && numChecks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    numErrors++;
    testDone();
  end
  initial begin
    boot(1'b1);
    for (int i = 0; i < 8; i++) rd(rowAddr[i], rowVal[i]);
    $display("test reset values done");
    wr(`STO_REG_CTRL, 32'h1);
    wr(`STO_REG_IRQ_MASK, 32'h7);
    wr(`STO_REG_PERIOD, 32'h4);
    runReq <= 1'b1;
    settle();
    `CHK(powerEnable, 1'b1)
    rd(`STO_REG_STATUS, 32'h28);
    selReq <= 1'b1;
    settle();
    `CHK({powerEnable, cutoffActive, switchOnInhibit}, 3'b011)
    `CHK(irq, 1'b1)
    rd(`STO_REG_IRQ_STAT, 32'h1);
    selReq <= 1'b0;
    settle();
    `CHK({powerEnable, cutoffActive, switchOnInhibit}, 3'b001)
    runReq <= 1'b0;
    settle();
    `CHK(switchOnInhibit, 1'b0)
    runReq <= 1'b1;
    settle();
    `CHK(powerEnable, 1'b1)
    wr(`STO_REG_IRQ_STAT, 32'h7);
    repeat (2) @(posedge clk);
    @(negedge clk);
    `CHK(irq, 1'b0)
    $display("test cutoff sequence done");
    wr(`STO_REG_CTRL, 32'h0);
    selReq <= 1'b1;
    settle();
    `CHK({cutoffActive, switchOnInhibit}, 2'b00)
    selReq <= 1'b0;
    // let the stale selection drain through the synchroniser before enabling
    settle();
    wr(`STO_REG_CTRL, 32'h1);
    chanB <= 16'h0011;
    repeat (12) @(posedge clk);
    @(negedge clk);
    `CHK({safetyFault, stopRequest, powerEnable}, 3'b110)
    rd(`STO_REG_FAULT, 32'h1);
    chanB <= 16'h0010; runReq <= 1'b0;
    wr(`STO_REG_CTRL, 32'h3);
    settle();
    `CHK({safetyFault, stopRequest}, 2'b00)
    wr(`STO_REG_LIMIT, 32'h0100);
    chanA <= 16'h0200; chanB <= 16'h0200;
    repeat (12) @(posedge clk);
    rd(`STO_REG_FAULT, 32'h2);
    $display("test fault handling done");
    boot(1'b0);
    wr(`STO_REG_CTRL, 32'h1);
    selReq <= 1'b1; runReq <= 1'b1;
    settle();
    `CHK({cutoffActive, switchOnInhibit}, 2'b00)
    `CHK(powerEnable, 1'b1)
    $display("test unsafe config done");
    testDone();
  end
endmodule
